// [pss_regs.sv]
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// (R1) Arbitration timeout sets a sticky flag; writing one clears it.
// (R2) Enabled port change of connected, bias, disabled or fault sets event.
// (R3) Resume completion on any port sets event when resume enable is one.
// (R4) Acceleration enable drives ack acceleration and fly-by arbitration.
// (R5) Software leaves acceleration enable alone while a bus request waits.
// (R6) Multi-speed enable lets concatenated packets keep their own speeds.
// (R7) Three-bit page pointer chooses what the paged addresses show.
// (R8) Four-bit port pointer chooses the port shown on the status page.
// (R9) Software sets port pointer to one with the vendor dependent page.
// (R10) Reserved bits always read as zero.
// (R11) Paged bytes carry line, topology, speed, enable and fault fields.
// (R12) Each pair line state reports invalid, one, zero or high impedance.
// (R13) Child shows topology; connected shows an attached peer.
// (R14) Bias bit reports detected bias voltage on the selected port.
// (R15) Per-port disabled bit is writable and resets to enabled.
// (R16) Negotiated speed reports the peer's top rate code.
// (R17) Suspend or resume error sets port fault; writing one clears it.
// (R18) Paged accesses use the pointers as they stand at access time.
module pss_regs
  import pss_pkg::*;
#(
  parameter int NPORTS = 3,
  parameter int AW     = 8
) (
  input  wire logic                   i_clock,
  input  wire logic                   i_rst_n,
  // AHB-Lite slave
  input  wire logic                   i_hsel,
  input  wire logic [AW-1:0]          i_haddr,
  input  wire logic [1:0]             i_htrans,
  input  wire logic                   i_hwrite,
  input  wire logic [2:0]             i_hsize,
  input  wire logic [31:0]            i_hwdata,
  input  wire logic                   i_hready,
  output logic                        o_hreadyout,
  output logic                        o_hresp,
  output logic [31:0]                 o_hrdata,
  // Device side
  input  wire logic                   i_arb_timeout,
  input  wire pss_port_in_t [NPORTS-1:0] i_port,
  output logic                        o_accel_en,
  output logic                        o_multi_en,
  output logic [NPORTS-1:0]           o_port_disabled
);

  // Bus sequencing states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WRITE,
    ST_RD_WAIT,
    ST_RD_DONE
  } pss_bus_st_t;

  pss_bus_st_t st_r, st_nxt;
  logic [3:0]  idx_r, idx_nxt;
  logic        hit_r, hit_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        take;
  logic        wr_en;
  logic [7:0]  wdata;
  logic [7:0]  rd_byte;

  // Control and event state
  logic        wdog_r, wdog_nxt;
  logic        tmo_r, tmo_nxt;
  logic        pev_r, pev_nxt;
  logic        accel_r, accel_nxt;
  logic        multi_r, multi_nxt;
  logic [2:0]  page_r, page_nxt;
  logic [3:0]  port_r, port_nxt;

  // Per-port wiring
  logic [NPORTS-1:0] wr_line;
  logic [NPORTS-1:0] wr_spd;
  logic [NPORTS-1:0] chg;
  logic [NPORTS-1:0] resume;
  logic [7:0]        line_byte [NPORTS];
  logic [7:0]        spd_byte  [NPORTS];

  // Decoded write strobes for the current data phase
  logic wr_evt;
  logic wr_sel;
  logic wr_pg_line;
  logic wr_pg_spd;
  logic pg_port;

  // Address phase taken only for a selected, ready, real transfer
  assign take  = i_hsel & i_hready & (i_htrans == HTRANS_NONSEQ);
  assign wdata = i_hwdata[7:0];

  // Reads get one wait state so the byte is sampled after any write
  // that finished in the same edge; writes complete with no wait.
  always_comb begin
    st_nxt    = st_r;
    idx_nxt   = idx_r;
    hit_nxt   = hit_r;
    rdata_nxt = rdata_r;
    wr_en     = 1'b0;
    unique case (st_r)
      ST_IDLE:    st_nxt = ST_IDLE;
      ST_WRITE:   wr_en = hit_r;
      ST_RD_WAIT: begin
        rdata_nxt = hit_r ? {24'h000000, rd_byte} : 32'h00000000;
        st_nxt    = ST_RD_DONE;
      end
      ST_RD_DONE: st_nxt = ST_RD_DONE;
    endcase
    // Only a ready cycle may close the old phase and open a new one
    if (st_r != ST_RD_WAIT) begin
      st_nxt = ST_IDLE;
      if (take) begin
        idx_nxt = i_haddr[5:2];
        hit_nxt = (i_haddr[1:0] == 2'h0)
                & (i_haddr[AW-1:6] == '0);
        st_nxt  = i_hwrite ? ST_WRITE : ST_RD_WAIT;
      end
    end
  end

  // Bus state registers
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r    <= ST_IDLE;
      idx_r   <= 4'h0;
      hit_r   <= 1'b0;
      rdata_r <= 32'h00000000;
    end else begin
      st_r    <= st_nxt;
      idx_r   <= idx_nxt;
      hit_r   <= hit_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign o_hreadyout = (st_r != ST_RD_WAIT);
  assign o_hresp     = 1'b0; // Always OKAY, unmapped reads give zero
  assign o_hrdata    = rdata_r;

  // Pointers are read live, so a pointer write takes effect at once
  assign pg_port    = (page_r == PAGE_PORT); // (R7)
  assign wr_evt     = wr_en & (idx_r == IDX_EVT);
  assign wr_sel     = wr_en & (idx_r == IDX_SEL);
  assign wr_pg_line = wr_en & (idx_r == IDX_PG_LINE) & pg_port; // (R18)
  assign wr_pg_spd  = wr_en & (idx_r == IDX_PG_SPD) & pg_port; // (R18)

  // Next values of the control and event bits
  always_comb begin
    wdog_nxt  = wdog_r;
    accel_nxt = accel_r;
    multi_nxt = multi_r;
    page_nxt  = page_r;
    port_nxt  = port_r;
    if (wr_evt) begin
      wdog_nxt  = wdata[EVT_WDOG_BIT];
      accel_nxt = wdata[EVT_ACCEL_BIT]; // (R4)
      multi_nxt = wdata[EVT_MULTI_BIT]; // (R6)
    end
    if (wr_sel) begin
      page_nxt = wdata[SEL_PAGE_LSB +: 3]; // (R7)
      port_nxt = wdata[SEL_PORT_LSB +: 4]; // (R8)
    end
    // Set beats clear when both land in one cycle
    tmo_nxt = (tmo_r & ~(wr_evt & wdata[EVT_TMO_BIT]))
            | i_arb_timeout; // (R1)
    pev_nxt = (pev_r & ~(wr_evt & wdata[EVT_PORTEV_BIT]))
            | (|chg) // (R2)
            | (wdog_r & (|resume)); // (R3)
  end

  // Control and event registers
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wdog_r  <= RST_FLAG;
      tmo_r   <= RST_FLAG;
      pev_r   <= RST_FLAG;
      accel_r <= RST_FLAG;
      multi_r <= RST_FLAG;
      page_r  <= RST_PAGE;
      port_r  <= RST_PORT;
    end else begin
      wdog_r  <= wdog_nxt;
      tmo_r   <= tmo_nxt;
      pev_r   <= pev_nxt;
      accel_r <= accel_nxt;
      multi_r <= multi_nxt;
      page_r  <= page_nxt;
      port_r  <= port_nxt;
    end
  end

  // Acceleration must not flip mid-request; software's duty, not ours
  assign o_accel_en = accel_r; // (R4)
  assign o_multi_en = multi_r; // (R6)

  // One state block per cable port; unused pointer codes hit none
  for (genvar i = 0; i < NPORTS; i++) begin : g_port
    assign wr_line[i] = wr_pg_line & (port_r == 4'(i)); // (R8)
    assign wr_spd[i]  = wr_pg_spd & (port_r == 4'(i)); // (R8)
    assign resume[i]  = i_port[i].resume_done;

    pss_port_state u_port (
      .i_clock     (i_clock),
      .i_rst_n     (i_rst_n),
      .i_stat      (i_port[i]),
      .i_wr_line   (wr_line[i]),
      .i_wr_spd    (wr_spd[i]),
      .i_wdata     (wdata),
      .o_disabled  (o_port_disabled[i]),
      .o_change    (chg[i]),
      .o_line_byte (line_byte[i]),
      .o_spd_byte  (spd_byte[i])
    );
  end

  // Read byte for the captured index; vendor pages read as zero here
  always_comb begin
    rd_byte = 8'h00; // (R10)
    unique case (idx_r)
      IDX_EVT: begin
        rd_byte[EVT_WDOG_BIT]   = wdog_r;
        rd_byte[EVT_TMO_BIT]    = tmo_r;
        rd_byte[EVT_PORTEV_BIT] = pev_r;
        rd_byte[EVT_ACCEL_BIT]  = accel_r;
        rd_byte[EVT_MULTI_BIT]  = multi_r;
      end
      IDX_SEL: begin
        rd_byte[SEL_PAGE_LSB +: 3] = page_r;
        rd_byte[SEL_PORT_LSB +: 4] = port_r;
      end
      IDX_PG_LINE: begin
        for (int k = 0; k < NPORTS; k++) begin
          if (pg_port && port_r == 4'(k)) begin
            rd_byte = line_byte[k]; // (R11)
          end
        end
      end
      IDX_PG_SPD: begin
        for (int k = 0; k < NPORTS; k++) begin
          if (pg_port && port_r == 4'(k)) begin
            rd_byte = spd_byte[k]; // (R11)
          end
        end
      end
      default: rd_byte = 8'h00;
    endcase
  end

endmodule
`default_nettype wire

// [pss_pkg.sv]
// Shared constants and carriers for the paged status and control block
package pss_pkg;

  // Register indices; byte address is four times the index
  localparam logic [3:0] IDX_EVT     = 4'h5;
  localparam logic [3:0] IDX_SEL     = 4'h7;
  localparam logic [3:0] IDX_PG_LINE = 4'h8;
  localparam logic [3:0] IDX_PG_SPD  = 4'h9;

  // Event and enable register fields
  localparam int EVT_MULTI_BIT  = 0;
  localparam int EVT_ACCEL_BIT  = 1;
  localparam int EVT_PORTEV_BIT = 2;
  localparam int EVT_TMO_BIT    = 3;
  localparam int EVT_WDOG_BIT   = 7;

  // Pointer register fields
  localparam int SEL_PORT_LSB = 0;
  localparam int SEL_PAGE_LSB = 5;

  // Port status page, line and topology byte
  localparam int LINE_A_LSB     = 0;
  localparam int LINE_B_LSB     = 2;
  localparam int LINE_CHILD_BIT = 4;
  localparam int LINE_CONN_BIT  = 5;
  localparam int LINE_BIAS_BIT  = 6;
  localparam int LINE_DIS_BIT   = 7;

  // Port status page, speed, enable and fault byte
  localparam int SPD_LSB       = 0;
  localparam int SPD_IRQ_BIT   = 3;
  localparam int SPD_FAULT_BIT = 4;

  // Page codes
  localparam logic [2:0] PAGE_PORT = 3'h0;
  localparam logic [2:0] PAGE_VID  = 3'h1;
  localparam logic [2:0] PAGE_VDEP = 3'h7;

  // Reset values
  localparam logic [2:0] RST_PAGE = 3'h0;
  localparam logic [3:0] RST_PORT = 4'h0;
  localparam logic       RST_FLAG = 1'b0;

  // Bus transfer type with a real access
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // Sensed line level codes
  typedef enum logic [1:0] {
    LINE_INVALID = 2'h0,
    LINE_ONE     = 2'h1,
    LINE_ZERO    = 2'h2,
    LINE_HIGHZ   = 2'h3
  } pss_line_t;

  // Peer rate codes
  typedef enum logic [2:0] {
    SPD_100 = 3'h0,
    SPD_200 = 3'h1,
    SPD_400 = 3'h2
  } pss_speed_t;

  // Live state of one cable port from the port logic
  typedef struct packed {
    pss_line_t  pair_a_line_state;
    pss_line_t  pair_b_line_state;
    logic       child;
    logic       connected;
    logic       bias;
    pss_speed_t speed;
    logic       resume_done;
    logic       susp_fault;
  } pss_port_in_t;

endpackage

// [pss_port_state.sv]
`timescale 1ns/1ps
`default_nettype none
// Per-port writable bits, fault flag, change detection and page bytes
module pss_port_state
  import pss_pkg::*;
(
  input  wire logic         i_clock,
  input  wire logic         i_rst_n,
  input  wire pss_port_in_t i_stat,
  input  wire logic         i_wr_line,
  input  wire logic         i_wr_spd,
  input  wire logic [7:0]   i_wdata,
  output logic              o_disabled,
  output logic              o_change,
  output logic [7:0]        o_line_byte,
  output logic [7:0]        o_spd_byte
);

  logic dis_r, dis_nxt;
  logic irq_r, irq_nxt;
  logic fault_r, fault_nxt;
  logic conn_q_r, bias_q_r, dis_q_r, fault_q_r;
  logic chg_r, chg_nxt;

  // Next values of the port's own bits
  always_comb begin
    dis_nxt = i_wr_line ? i_wdata[LINE_DIS_BIT] : dis_r; // (R15)
    irq_nxt = i_wr_spd ? i_wdata[SPD_IRQ_BIT] : irq_r;
    // A fault seen in the clearing cycle survives the clear
    fault_nxt = (fault_r & ~(i_wr_spd & i_wdata[SPD_FAULT_BIT]))
              | i_stat.susp_fault; // (R17)
    // Compare against last cycle's copy of the watched bits
    chg_nxt = irq_r & ((conn_q_r != i_stat.connected)
                     | (bias_q_r != i_stat.bias)
                     | (dis_q_r != dis_r)
                     | (fault_q_r != fault_r)); // (R2)
  end

  // Port bits; all enabled and clear after reset
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dis_r     <= RST_FLAG;
      irq_r     <= RST_FLAG;
      fault_r   <= RST_FLAG;
      conn_q_r  <= RST_FLAG;
      bias_q_r  <= RST_FLAG;
      dis_q_r   <= RST_FLAG;
      fault_q_r <= RST_FLAG;
      chg_r     <= RST_FLAG;
    end else begin
      dis_r     <= dis_nxt;
      irq_r     <= irq_nxt;
      fault_r   <= fault_nxt;
      conn_q_r  <= i_stat.connected;
      bias_q_r  <= i_stat.bias;
      dis_q_r   <= dis_r;
      fault_q_r <= fault_r;
      chg_r     <= chg_nxt;
    end
  end

  assign o_disabled = dis_r;
  assign o_change   = chg_r;

  // Page bytes as software sees them for this port
  always_comb begin
    o_line_byte = 8'h00;
    o_line_byte[LINE_A_LSB +: 2] = i_stat.pair_a_line_state; // (R12)
    o_line_byte[LINE_B_LSB +: 2] = i_stat.pair_b_line_state; // (R12)
    o_line_byte[LINE_CHILD_BIT]  = i_stat.child; // (R13)
    o_line_byte[LINE_CONN_BIT]   = i_stat.connected; // (R13)
    o_line_byte[LINE_BIAS_BIT]   = i_stat.bias; // (R14)
    o_line_byte[LINE_DIS_BIT]    = dis_r;
    o_spd_byte = 8'h00; // (R10)
    o_spd_byte[SPD_LSB +: 3]   = i_stat.speed; // (R16)
    o_spd_byte[SPD_IRQ_BIT]    = irq_r;
    o_spd_byte[SPD_FAULT_BIT]  = fault_r;
  end

endmodule
`default_nettype wire

// [pss_regs_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
// Watches the register bus and control outputs of the paged block
module pss_regs_monitor
  import pss_pkg::*;
#(
  parameter int NPORTS = 3,
  parameter int AW     = 8
) (
  input wire logic              i_clock,
  input wire logic              i_rst_n,
  input wire logic              i_hsel,
  input wire logic [AW-1:0]     i_haddr,
  input wire logic [1:0]        i_htrans,
  input wire logic              i_hwrite,
  input wire logic [31:0]       i_hwdata,
  input wire logic              i_hready,
  input wire logic              o_hreadyout,
  input wire logic [31:0]       o_hrdata,
  input wire logic              o_accel_en,
  input wire logic              o_multi_en,
  input wire logic [NPORTS-1:0] o_port_disabled
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  logic       taken;
  logic       mapped;
  logic [3:0] idx;
  logic       w5_r;
  logic       w8_r;
  // Address phase decode, as the slave sees it
  assign taken = i_hsel && i_hready && i_htrans == HTRANS_NONSEQ;
  assign idx = i_haddr[5:2];
  assign mapped = i_haddr[1:0] == 2'h0 && (i_haddr >> 6) == '0 &&
    (idx == IDX_EVT || idx == IDX_SEL || idx == IDX_PG_LINE ||
     idx == IDX_PG_SPD);
  // Marks write data phases; writes never wait, so one cycle each
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      w5_r <= 1'h0;
      w8_r <= 1'h0;
    end else begin
      w5_r <= taken && i_hwrite && mapped && idx == IDX_EVT;
      w8_r <= taken && i_hwrite && mapped && idx == IDX_PG_LINE;
    end
  end
  chk_accel_wr: assert property (
    w5_r |=> o_accel_en == $past(i_hwdata[EVT_ACCEL_BIT]))
    else $error("accel enable not loaded");
  chk_multi_wr: assert property (
    w5_r |=> o_multi_en == $past(i_hwdata[EVT_MULTI_BIT]))
    else $error("multi enable not loaded");
  chk_accel_hold: assert property (
    !w5_r |=> $stable(o_accel_en))
    else $error("accel enable moved without a write");
  chk_dis_hold: assert property (
    !w8_r |=> $stable(o_port_disabled))
    else $error("disabled bits moved without a write");
  chk_reset_clear: assert property (
    $rose(i_rst_n) |-> !o_accel_en && !o_multi_en && o_port_disabled == '0)
    else $error("controls not cleared by reset");
  chk_read_wait: assert property (
    taken && !i_hwrite |=> !o_hreadyout ##1 o_hreadyout)
    else $error("read wait state wrong");
  chk_write_fast: assert property (
    taken && i_hwrite |=> o_hreadyout)
    else $error("write data phase stalled");
  chk_unmapped_zero: assert property (
    taken && !i_hwrite && !mapped |=> ##1 o_hrdata == 32'h0)
    else $error("unmapped read not zero");
  chk_upper_zero: assert property (
    o_hreadyout |-> o_hrdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  cover property (taken && !i_hwrite && !mapped);
  cover property (w5_r);
  cover property (w8_r);
endmodule

bind pss_regs pss_regs_monitor #(.NPORTS(NPORTS), .AW(AW)) mon (
  .i_clock, .i_rst_n, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hwdata,
  .i_hready, .o_hreadyout, .o_hrdata, .o_accel_en, .o_multi_en,
  .o_port_disabled
);
`default_nettype wire

// [pss_host.sv]
`timescale 1ns/1ps
`default_nettype none
// Link controller model: single word transfers on the register bus
module pss_host (
  input  wire logic        i_clock,
  input  wire logic        i_hready,
  input  wire logic [31:0] i_hrdata,
  output logic             o_hsel,
  output logic [7:0]       o_haddr,
  output logic [1:0]       o_htrans,
  output logic             o_hwrite,
  output logic [2:0]       o_hsize,
  output logic [31:0]      o_hwdata
);
  // Idle bus at time zero
  initial begin
    o_hsel = 1'h0;
    o_haddr = 8'h0;
    o_htrans = 2'h0;
    o_hwrite = 1'h0;
    o_hsize = 3'h2;
    o_hwdata = 32'h0;
  end
  // Looks at ready just before the edge, so no race with the slave
  task automatic wait_rdy(output bit ok);
    ok = 1'h0;
    for (int n = 0; n < 64 && !ok; n++) begin
      @(negedge i_clock);
      ok = i_hready;
    end
    @(posedge i_clock);
  endtask
  // Released lines carry inverted values so stale data cannot match
  task automatic xfer(input bit w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output bit ok);
    bit ok2;
    @(posedge i_clock);
    o_hsel <= 1'h1;
    o_htrans <= 2'h2;
    o_haddr <= a;
    o_hwrite <= w;
    wait_rdy(ok);
    o_htrans <= 2'h0;
    o_haddr <= ~a;
    o_hwdata <= w ? d : ~d;
    wait_rdy(ok2);
    q = i_hrdata;
    o_hsel <= 1'h0;
    o_hwdata <= ~d;
    ok = ok && ok2;
  endtask
endmodule
`default_nettype wire

// [phy_paged_status_control_regs_bench.sv]
`timescale 1ns/1ps
`default_nettype none
// Exercises the paged status and control registers end to end
module phy_paged_status_control_regs_bench
  import pss_pkg::*;
;
  logic               clk;
  logic               rst_n;
  logic               hsel;
  logic               hwrite;
  logic               hready;
  logic               hresp;
  logic               tmo;
  logic               accel;
  logic               multi;
  logic [7:0]         haddr;
  logic [1:0]         htrans;
  logic [2:0]         hsize;
  logic [2:0]         dis;
  logic [31:0]        hwdata;
  logic [31:0]        hrdata;
  pss_port_in_t [2:0] prt;
  int                 num_errors = 0;
  int                 checked = 0;

  pss_regs #(.NPORTS(3), .AW(8)) uut (
    .i_clock(clk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
    .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready),
    .o_hresp(hresp), .o_hrdata(hrdata), .i_arb_timeout(tmo), .i_port(prt),
    .o_accel_en(accel), .o_multi_en(multi), .o_port_disabled(dis)
  );
  pss_host host (
    .i_clock(clk), .i_hready(hready), .i_hrdata(hrdata), .o_hsel(hsel),
    .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite),
    .o_hsize(hsize), .o_hwdata(hwdata)
  );

  // Free running clock, 8 ns period
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  task automatic summarize;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h got %h", nm, e, g);
    end
  endtask
  // A bus hang ends the run at once
  task automatic bus(bit w, logic [3:0] i, logic [7:0] d,
                     output logic [31:0] q);
    bit ok;
    host.xfer(w, {2'h0, i, 2'h0}, {24'h0, d}, q, ok);
    if (!ok) begin
      num_errors++;
      $display("ERROR bus ready expected 1 got 0");
      summarize();
    end
  endtask
  task automatic wr(logic [3:0] i, logic [7:0] d);
    logic [31:0] q;
    bus(1'h1, i, d, q);
    // Let the closing edge's register updates settle before callers look
    @(negedge clk);
  endtask
  task automatic rdc(string nm, logic [3:0] i, logic [7:0] e);
    logic [31:0] q;
    bus(1'h0, i, 8'h0, q);
    chk(nm, {24'h0, e}, q);
    chk("resp", 32'h0, {31'h0, hresp});
  endtask
  // Expected line byte of a port, bit 7 downward
  function automatic logic [7:0] lb(int p, logic d);
    return {d, prt[p].bias, prt[p].connected, prt[p].child,
            prt[p].pair_b_line_state, prt[p].pair_a_line_state};
  endfunction
  task automatic t_ports;
    for (int p = 0; p < 4; p++) begin
      wr(IDX_SEL, 8'(p));
      rdc("line", IDX_PG_LINE, p < 3 ? lb(p, 1'h0) : 8'h0);
      rdc("spd", IDX_PG_SPD, p < 3 ? {5'h0, prt[p].speed} : 8'h0);
    end
    wr(IDX_SEL, 8'hff);
    rdc("sel", IDX_SEL, 8'hef);
    rdc("unused page", IDX_PG_LINE, 8'h0);
    wr(IDX_SEL, {PAGE_VID, 5'h0});
    rdc("vid page", IDX_PG_SPD, 8'h0);
    wr(IDX_SEL, {PAGE_VDEP, 5'h1});
    rdc("vdep sel", IDX_SEL, 8'he1);
    $display("ports done");
  endtask
  task automatic t_enables;
    wr(IDX_EVT, 8'h03);
    chk("accel", 32'h1, {31'h0, accel});
    chk("multi", 32'h1, {31'h0, multi});
    rdc("en", IDX_EVT, 8'h03);
    wr(IDX_EVT, 8'h00);
    chk("accel off", 32'h0, {31'h0, accel});
    chk("multi off", 32'h0, {31'h0, multi});
    $display("enables done");
  endtask
  task automatic t_timeout;
    @(posedge clk);
    tmo <= 1'h1;
    @(posedge clk);
    tmo <= 1'h0;
    rdc("tmo set", IDX_EVT, 8'h08);
    wr(IDX_EVT, 8'h00);
    rdc("tmo kept", IDX_EVT, 8'h08);
    wr(IDX_EVT, 8'h08);
    rdc("tmo clr", IDX_EVT, 8'h00);
    $display("timeout done");
  endtask
  task automatic t_dis_fault;
    wr(IDX_SEL, 8'h02);
    wr(IDX_PG_LINE, 8'h80);
    chk("dis", 32'h4, {29'h0, dis});
    rdc("dis rd", IDX_PG_LINE, lb(2, 1'h1));
    wr(IDX_PG_SPD, 8'he0);
    rdc("spd rsv", IDX_PG_SPD, {5'h0, prt[2].speed});
    wr(IDX_PG_LINE, 8'h00);
    wr(IDX_SEL, 8'h00);
    @(posedge clk);
    prt[0].susp_fault <= 1'h1;
    @(posedge clk);
    prt[0].susp_fault <= 1'h0;
    rdc("fault", IDX_PG_SPD, 8'h10);
    wr(IDX_PG_SPD, 8'h00);
    rdc("fault kept", IDX_PG_SPD, 8'h10);
    wr(IDX_PG_SPD, 8'h10);
    rdc("fault clr", IDX_PG_SPD, 8'h00);
    rdc("no event", IDX_EVT, 8'h00);
    $display("disable and fault done");
  endtask
  task automatic t_change;
    wr(IDX_SEL, 8'h01);
    wr(IDX_PG_SPD, 8'h08);
    rdc("irq rd", IDX_PG_SPD, 8'h09);
    wr(IDX_EVT, 8'h04);
    @(posedge clk);
    prt[1].connected <= 1'h0;
    rdc("chg set", IDX_EVT, 8'h04);
    wr(IDX_EVT, 8'h04);
    rdc("chg clr", IDX_EVT, 8'h00);
    // A software write to the disabled bit counts as a change too
    wr(IDX_PG_LINE, 8'h80);
    chk("dis p1", 32'h2, {29'h0, dis});
    rdc("dis chg", IDX_EVT, 8'h04);
    wr(IDX_EVT, 8'h04);
    @(posedge clk);
    prt[0].bias <= 1'h0;
    rdc("chg masked", IDX_EVT, 8'h00);
    $display("change done");
  endtask
  task automatic t_resume;
    wr(IDX_EVT, 8'h80);
    @(posedge clk);
    prt[2].resume_done <= 1'h1;
    @(posedge clk);
    prt[2].resume_done <= 1'h0;
    rdc("resume", IDX_EVT, 8'h84);
    wr(IDX_EVT, 8'h04);
    @(posedge clk);
    prt[2].resume_done <= 1'h1;
    @(posedge clk);
    prt[2].resume_done <= 1'h0;
    rdc("resume off", IDX_EVT, 8'h00);
    $display("resume done");
  endtask
  // Reset in mid-run must drop every control back to its idle value
  task automatic t_reset;
    wr(IDX_EVT, 8'h03);
    @(posedge clk);
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    @(negedge clk);
    chk("accel rst", 32'h0, {31'h0, accel});
    chk("multi rst", 32'h0, {31'h0, multi});
    chk("dis rst", 32'h0, {29'h0, dis});
    rdc("sel rst2", IDX_SEL, 8'h00);
    rdc("evt rst2", IDX_EVT, 8'h00);
    $display("reset again done");
  endtask
  // Reset, then every scenario in turn
  initial begin
    rst_n = 1'h0;
    tmo = 1'h0;
    for (int p = 0; p < 3; p++) begin
      prt[p] = '{pss_line_t'(p), pss_line_t'(3 - p), p[0], 1'h1,
                 p != 1, pss_speed_t'(p), 1'h0, 1'h0};
    end
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    rdc("evt rst", IDX_EVT, 8'h00);
    rdc("sel rst", IDX_SEL, 8'h00);
    rdc("unmapped", 4'h3, 8'h00);
    $display("reset done");
    t_ports();
    t_enables();
    t_timeout();
    t_dis_fault();
    t_change();
    t_resume();
    t_reset();
    summarize();
  end
endmodule
`default_nettype wire
